// File: src/apl_pkg.sv
// Package for the pod link framing block: constants, types and the notes on behaviour.
// Assumes one 100 MHz clock, a synchronous active-high reset and a host that waits for each reply.
// Notes on behaviour
// [R1] Serial characters use seven data bits, even parity and one stop bit.
// [R2] All numbers in commands and replies are ASCII hexadecimal digits.
// [R3] The pod talks at 9600 baud out of reset.
// [R4] Pod address 00 means non-addressed mode; any other value means addressed mode.
// [R5] Host sends select: exclamation mark, two hex digits 01 to FF, terminator.
// [R6] Every command ends with carriage return, code 13; receiver treats it as end.
// [R7] Matching select replies two address digits, Y or N, then carriage return.
// [R8] Selected pod executes commands until next select; unselected pods ignore traffic.
// [R9] Non-addressed pod executes commands without any select.
// [R10] Characters are matched case-sensitively.
// [R11] A whole message stays shorter than 255 characters.
// [R12] Host waits for each reply before sending the next command.
// [R13] Characters are buffered to the terminator; overlong unterminated messages are dropped.
package apl_pkg;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ       = 100_000_000;
	localparam int BAUD_RATE    = 9600;
	localparam int BIT_CYC      = CLK_HZ / BAUD_RATE;
	localparam int DATA_BITS    = 7;
	localparam int STOP_BITS    = 1;
	// ---------------------------------------------------------------
	// Characters and limits
	// ---------------------------------------------------------------
	localparam logic [6:0] CH_CR   = 7'h0D;
	localparam logic [6:0] CH_SEL  = 7'h21;
	localparam logic [6:0] CH_Y    = 7'h59;
	localparam logic [6:0] CH_N    = 7'h4E;
	localparam int         MSG_MAX = 255;
	localparam logic [7:0] ADDR_NONE = 8'h00;
	localparam int         IDX_W   = 8;
	// Receive character strobe group shared with the serial front end.
	typedef struct packed {
		logic       valid;
		logic [6:0] data;
		logic       perr;
	} apl_char_s;
endpackage : apl_pkg

// File: src/apl_char_if.sv
// Interface carrying received and transmitted characters between the front end and the parser.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface apl_char_if;
	import apl_pkg::*;
	apl_char_s  rx;      // Received character strobe.
	logic       tx_go;   // Transmit request pulse.
	logic [6:0] tx_data; // Character to send.
	logic       tx_busy; // Transmitter busy.
	modport ser (output rx, input tx_go, input tx_data, output tx_busy);
	modport prs (input rx, output tx_go, output tx_data, input tx_busy);
endinterface : apl_char_if

// File: src/apl_uart.sv
// Serial front end: 7E1 receiver and transmitter at the fixed rate.
// Assumes the line input is already synchronous to the clock.
`timescale 1ns/1ps
module apl_uart
	import apl_pkg::*;
(
	input  wire logic i_clk,     // System clock.
	input  wire logic i_sys_rst, // Synchronous reset.
	input  wire logic i_rxd,     // Serial line in.
	output logic      o_txd,     // Serial line out.
	apl_char_if.ser   ch         // Character port.
);
	typedef enum logic [1:0] {S_IDLE, S_RUN} apl_st_e;
	typedef struct packed {
		apl_st_e     rst;
		logic [15:0] rcnt;
		logic [3:0]  rbit;
		logic [7:0]  rsh;
		apl_char_s   rx;
		apl_st_e     tst;
		logic [15:0] tcnt;
		logic [3:0]  tbit;
		logic [9:0]  tsh;
		logic        txd;
	} apl_uart_s;
	apl_uart_s s_r, s_nxt;
	// ---------------------------------------------------------------
	// Receive and transmit sequencing
	// ---------------------------------------------------------------
	// Bits are sampled mid-cell; the frame is start, 7 data, parity, stop.
	always_comb begin
		s_nxt = s_r;
		s_nxt.rx.valid = 1'b0;
		case (s_r.rst)
			S_IDLE: if (!i_rxd) begin
				s_nxt.rst  = S_RUN;
				s_nxt.rcnt = 16'(BIT_CYC / 2);
				s_nxt.rbit = 4'h0;
			end
			S_RUN: if (s_r.rcnt == 16'h0000) begin
				s_nxt.rcnt = 16'(BIT_CYC - 1); // [R3]
				s_nxt.rbit = s_r.rbit + 4'h1;
				if (s_r.rbit == 4'h0 && i_rxd) s_nxt.rst = S_IDLE; // False start.
				else if (s_r.rbit == 4'(DATA_BITS + 2)) begin // [R1]
					s_nxt.rst = S_IDLE;
					s_nxt.rx.valid = 1'b1;
					s_nxt.rx.data = s_r.rsh[6:0];
					s_nxt.rx.perr = (^s_r.rsh) | ~i_rxd; // Even parity and stop check.
				end else if (s_r.rbit != 4'h0) s_nxt.rsh = {i_rxd, s_r.rsh[7:1]};
			end else s_nxt.rcnt = s_r.rcnt - 16'h0001;
			default: s_nxt.rst = S_IDLE;
		endcase
		case (s_r.tst)
			S_IDLE: begin
				s_nxt.txd = 1'b1;
				if (ch.tx_go) begin
					s_nxt.tst  = S_RUN;
					s_nxt.tsh  = {1'b1, ^ch.tx_data, ch.tx_data, 1'b0}; // [R1]
					s_nxt.tcnt = 16'h0000;
					s_nxt.tbit = 4'h0;
				end
			end
			S_RUN: if (s_r.tcnt == 16'h0000) begin
				if (s_r.tbit == 4'(DATA_BITS + 2 + STOP_BITS)) s_nxt.tst = S_IDLE;
				else begin
					s_nxt.txd  = s_r.tsh[0];
					s_nxt.tsh  = {1'b1, s_r.tsh[9:1]};
					s_nxt.tbit = s_r.tbit + 4'h1;
					s_nxt.tcnt = 16'(BIT_CYC - 1);
				end
			end else s_nxt.tcnt = s_r.tcnt - 16'h0001;
			default: s_nxt.tst = S_IDLE;
		endcase
	end
	// State register.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			s_r     <= '0;
			s_r.txd <= 1'b1;
		end else s_r <= s_nxt;
	end
	assign o_txd      = s_r.txd;
	assign ch.rx      = s_r.rx;
	// Busy comes from state only; folding tx_go in would close a loop through the parser's request logic.
	assign ch.tx_busy = (s_r.tst != S_IDLE);
	// Start of a transmit frame drives the line low one bit cell.
	a_tx_start: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(s_r.tst == S_IDLE && ch.tx_go) |=> ##1 !o_txd) else $error("start bit missing"); // [R1]
	a_bit_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(s_r.tst == S_RUN && s_r.tcnt == 16'h0000 && s_r.tbit == 4'h1) |=>
		s_r.tcnt == 16'(BIT_CYC - 1)) else $error("bit cell length wrong"); // [R3]
endmodule : apl_uart

// File: src/apl_pod_link.sv
// Pod link framing top: buffers commands, handles pod select and addressed mode.
// Assumes the host waits for each reply before the next command.
`timescale 1ns/1ps
module apl_pod_link
	import apl_pkg::*;
(
	input  wire logic       i_clk,        // System clock.
	input  wire logic       i_sys_rst,    // Synchronous reset.
	input  wire logic       i_rxd,        // Serial line in.
	output logic            o_txd,        // Serial line out.
	input  wire logic [7:0] i_pod_addr,   // Stored pod address.
	input  wire logic       i_cos_event,  // Enabled input changed state.
	output logic            o_cmd_valid,  // Command ready pulse.
	output logic [6:0]      o_cmd_char,   // Buffered character at i_cmd_idx.
	output logic [7:0]      o_cmd_len,    // Command length without terminator.
	input  wire logic [7:0] i_cmd_idx,    // Read index into command buffer.
	input  wire logic       i_cmd_done,   // Consumer finished the command.
	output logic            o_selected,   // Pod is executing commands.
	output logic            o_addressed   // Addressed mode active.
);
	typedef enum logic [2:0] {P_RX, P_DEC, P_REPLY, P_WAIT, P_EXEC} apl_ps_e;
	typedef struct packed {
		apl_ps_e     st;
		logic [7:0]  len;
		logic        drop;
		logic        sel;
		logic        cos;
		logic [1:0]  rix;
		logic [7:0]  cmd_len;
		logic        cmd_v;
		logic [6:0]  cmd_ch;
	} apl_link_s;
	apl_link_s   s_r, s_nxt;
	logic [6:0]  buf_r [MSG_MAX];
	logic [7:0]  sel_addr;
	logic        hex_ok;
	logic        is_sel;
	logic [6:0]  rep_ch;
	apl_char_if  ch ();
	// ---------------------------------------------------------------
	// Serial front end
	// ---------------------------------------------------------------
	apl_uart u_uart (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_rxd     (i_rxd),
		.o_txd     (o_txd),
		.ch        (ch.ser)
	);
	// Hex digit decode, upper case only since matching is case-sensitive.
	function automatic logic [4:0] hex_val(input logic [6:0] c);
		if (c >= 7'h30 && c <= 7'h39) hex_val = {1'b1, 4'(c - 7'h30)}; // [R2]
		else if (c >= 7'h41 && c <= 7'h46) hex_val = {1'b1, 4'(c - 7'h37)}; // [R10]
		else hex_val = 5'h00;
	endfunction : hex_val
	function automatic logic [6:0] hex_chr(input logic [3:0] v);
		hex_chr = (v < 4'hA) ? 7'(7'h30 + v) : 7'(7'h37 + v); // [R2]
	endfunction : hex_chr
	// ---------------------------------------------------------------
	// Select decode
	// ---------------------------------------------------------------
	// A select is exactly three characters before the terminator.
	always_comb begin
		logic [4:0] hi;
		logic [4:0] lo;
		hi       = hex_val(buf_r[1]);
		lo       = hex_val(buf_r[2]);
		sel_addr = {hi[3:0], lo[3:0]};
		hex_ok   = hi[4] & lo[4];
		is_sel   = (s_r.len == 8'h03) && (buf_r[0] == CH_SEL); // [R5] [R10]
		case (s_r.rix)
			2'h0:    rep_ch = buf_r[1];
			2'h1:    rep_ch = buf_r[2];
			2'h2:    rep_ch = s_r.cos ? CH_Y : CH_N; // [R7]
			default: rep_ch = CH_CR;
		endcase
	end
	// ---------------------------------------------------------------
	// Framing state machine
	// ---------------------------------------------------------------
	// A set from a new input change wins over the clear done by a select reply.
	always_comb begin
		s_nxt = s_r;
		s_nxt.cmd_v = 1'b0;
		s_nxt.cmd_ch = buf_r[i_cmd_idx < 8'(MSG_MAX) ? i_cmd_idx : 8'h00];
		ch.tx_go = 1'b0;
		ch.tx_data = rep_ch;
		case (s_r.st)
			P_RX: if (ch.rx.valid) begin
				if (ch.rx.data == CH_CR) begin // [R6]
					if (s_r.drop || ch.rx.perr) s_nxt.len = 8'h00;
					else s_nxt.st = P_DEC;
					s_nxt.drop = 1'b0;
				end else if (s_r.len == 8'(MSG_MAX - 1)) begin
					s_nxt.drop = 1'b1; // [R11] [R13]
					s_nxt.len  = 8'h00;
				end else if (!s_r.drop) s_nxt.len = s_r.len + 8'h01; // [R13]
			end
			P_DEC: begin
				s_nxt.len = 8'h00;
				s_nxt.st  = P_RX;
				if (is_sel && i_pod_addr != ADDR_NONE) begin // [R5]
					s_nxt.sel = hex_ok && sel_addr == i_pod_addr; // [R8]
					if (hex_ok && sel_addr == i_pod_addr) begin
						s_nxt.st  = P_REPLY;
						s_nxt.rix = 2'h0;
						s_nxt.len = s_r.len;
					end
				end else if (i_pod_addr == ADDR_NONE || s_r.sel) begin // [R4] [R8] [R9]
					s_nxt.st      = P_EXEC;
					s_nxt.cmd_v   = 1'b1;
					s_nxt.cmd_len = s_r.len;
					s_nxt.len     = s_r.len;
				end
			end
			P_REPLY: if (!ch.tx_busy) begin
				ch.tx_go = 1'b1; // [R7]
				s_nxt.st = P_WAIT;
			end
			P_WAIT: if (!ch.tx_busy) begin
				s_nxt.rix = s_r.rix + 2'h1;
				if (s_r.rix == 2'h2) s_nxt.cos = 1'b0; // [R7]
				if (s_r.rix == 2'h3) begin
					s_nxt.st  = P_RX;
					s_nxt.len = 8'h00;
				end else s_nxt.st = P_REPLY;
			end
			P_EXEC: if (i_cmd_done) begin
				s_nxt.st  = P_RX;
				s_nxt.len = 8'h00;
			end
			default: s_nxt.st = P_RX;
		endcase
		if (i_cos_event) s_nxt.cos = 1'b1;
	end
	// State register and character buffer.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) s_r <= '0;
		else begin
			s_r <= s_nxt;
			if (s_r.st == P_RX && ch.rx.valid && ch.rx.data != CH_CR && s_r.len < 8'(MSG_MAX - 1))
				buf_r[s_r.len] <= ch.rx.data; // [R13]
		end
	end
	assign o_cmd_valid = s_r.cmd_v;
	assign o_cmd_char  = s_r.cmd_ch;
	assign o_cmd_len   = s_r.cmd_len;
	assign o_selected  = s_r.sel || i_pod_addr == ADDR_NONE;
	assign o_addressed = i_pod_addr != ADDR_NONE; // [R4]
	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence sel_seen;
		s_r.st == P_DEC && is_sel && hex_ok && sel_addr == i_pod_addr && i_pod_addr != ADDR_NONE;
	endsequence
	a_sel_reply: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		sel_seen |=> s_r.st == P_REPLY && s_r.sel) else $error("select not answered"); // [R7]
	a_unsel_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(s_r.st == P_DEC && o_addressed && !s_r.sel && !is_sel) |=> !o_cmd_valid)
		else $error("unselected pod executed"); // [R8]
	a_direct_exec: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(s_r.st == P_DEC && !o_addressed) |=> o_cmd_valid) else $error("direct command lost"); // [R9]
	a_len_limit: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		s_r.len < 8'(MSG_MAX)) else $error("message too long"); // [R11]
	a_cr_ends: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(s_r.st == P_RX && ch.rx.valid && ch.rx.data == CH_CR && !ch.rx.perr && !s_r.drop) |=>
		s_r.st == P_DEC) else $error("terminator not seen"); // [R6]
	a_cos_sticky: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_cos_event |=> s_r.cos) else $error("change of state lost"); // [R7]
	a_mode_map: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_addressed == (i_pod_addr != 8'h00)) else $error("mode wrong"); // [R4]
	a_drop_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(s_r.st == P_RX && ch.rx.valid && ch.rx.data != CH_CR && s_r.len == 8'(MSG_MAX - 1)) |=>
		s_r.drop && s_r.len == 8'h00) else $error("overlong not dropped"); // [R13]
endmodule : apl_pod_link

// File: sim/apl_host_model.sv
// Host model: sends and receives 7E1 characters on the pod's serial pins.
// Assumes the pod clock, the fixed bit cell and an idle-high line.
`timescale 1ns/1ps
module apl_host_model
	import apl_pkg::*;
(
	input  wire logic i_clk, // System clock.
	input  wire logic i_txd, // Pod serial out.
	output logic      o_rxd  // Pod serial in.
);
	// ---------------------------------------------------------------
	// Transmit and receive
	// ---------------------------------------------------------------
	logic [6:0] rx_q[$];
	int         bad_frames;
	initial begin
		o_rxd      = 1'b1;
		bad_frames = 0;
	end
	// Start, seven data bits low first, even parity, one stop bit.
	task automatic send_char(input logic [6:0] c);
		logic [9:0] f;
		f = {1'b1, ^c, c, 1'b0};
		for (int i = 0; i < 10; i++) begin
			o_rxd = f[i];
			repeat (BIT_CYC) @(posedge i_clk);
			#1;
		end
	endtask : send_char
	// Samples mid-cell: seven data bits, parity, then stop; it stops at the stop bit so that
	// a start bit following closely behind is not missed.
	initial forever begin
		logic [8:0] f;
		@(negedge i_txd);
		repeat (BIT_CYC / 2) @(posedge i_clk);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT_CYC) @(posedge i_clk);
			f[i] = i_txd;
		end
		if (f[8] !== 1'b1 || ^f[7:0] !== 1'b0) bad_frames++;
		else rx_q.push_back(f[6:0]);
	end
endmodule : apl_host_model

// File: sim/apl_pod_link_tb.sv
// Testbench for the pod link framing top, driven through the host model.
// Assumes the fixed serial rate; each character takes about 104k cycles.
`timescale 1ns/1ps
module apl_pod_link_tb;
	import apl_pkg::*;
	logic       clk, rst, rxd, txd, cos, cmd_valid, cmd_done, selected, addressed;
	logic [7:0] pod_addr, cmd_len, cmd_idx;
	logic [6:0] cmd_char;
	int         err_count, checked;
	// ---------------------------------------------------------------
	// Clock, design and partner
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	apl_pod_link u_dut (.i_clk(clk), .i_sys_rst(rst), .i_rxd(rxd), .o_txd(txd), .i_pod_addr(pod_addr),
		.i_cos_event(cos), .o_cmd_valid(cmd_valid), .o_cmd_char(cmd_char), .o_cmd_len(cmd_len),
		.i_cmd_idx(cmd_idx), .i_cmd_done(cmd_done), .o_selected(selected), .o_addressed(addressed));
	apl_host_model u_host (.i_clk(clk), .i_txd(txd), .o_rxd(rxd));
	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic print_verdict();
		$display("checked=%0d err_count=%0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// Sends text, CR appended by caller, watching for a command pulse meanwhile.
	task automatic send_cmd(input string s, output logic got);
		got = 1'b0;
		fork
			for (int i = 0; i < s.len(); i++) u_host.send_char(7'(s[i]));
			for (int n = 0; n < (s.len() + 1) * 10 * BIT_CYC; n++) begin
				tick(1);
				if (cmd_valid === 1'b1) begin
					got = 1'b1;
					break;
				end
			end
		join
	endtask : send_cmd
	// Reads the first buffered character and frees the receiver.
	task automatic consume(input logic [6:0] c, input logic [7:0] len);
		cmd_idx = 8'h00;
		tick(2);
		check("cmd_char", {1'b0, cmd_char}, {1'b0, c});
		check("cmd_len", cmd_len, len);
		cmd_done = 1'b1;
		tick(1);
		cmd_done = 1'b0;
		tick(2);
	endtask : consume
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_nonaddr();
		logic got;
		pod_addr = ADDR_NONE;
		tick(1);
		check("addressed", addressed, 1'b0);
		send_cmd("a\015", got);
		check("valid", got, 1'b1);
		if (got) consume(7'h61, 8'h01);
	endtask : t_nonaddr
	task automatic t_unselected();
		logic got;
		pod_addr = 8'h05;
		tick(1);
		check("addressed", addressed, 1'b1);
		check("selected", selected, 1'b0);
		send_cmd("b\015", got);
		check("valid", got, 1'b0);
		tick(BIT_CYC * 12);
		check("reply count", 8'(u_host.rx_q.size()), 8'h00);
	endtask : t_unselected
	task automatic t_select();
		logic got;
		logic [6:0] exp[4] = '{7'h30, 7'h35, CH_Y, CH_CR};
		cos = 1'b1;
		tick(1);
		cos = 1'b0;
		send_cmd("!05\015", got);
		for (int n = 0; n < 50 * BIT_CYC && u_host.rx_q.size() < 4; n++) tick(1);
		check("reply count", 8'(u_host.rx_q.size()), 8'h04);
		// A missing reply character is judged against zero so that a short reply still fails here.
		for (int i = 0; i < 4; i++) check("reply", (i < u_host.rx_q.size()) ? {1'b0, u_host.rx_q[i]} : 8'h00, {1'b0, exp[i]});
		check("bad frames", 8'(u_host.bad_frames), 8'h00);
		u_host.rx_q.delete();
		check("selected", selected, 1'b1);
		send_cmd("c\015", got);
		check("valid", got, 1'b1);
		if (got) consume(7'h63, 8'h01);
		send_cmd("!06\015", got);
		tick(BIT_CYC * 45);
		check("reply count", 8'(u_host.rx_q.size()), 8'h00);
		check("selected", selected, 1'b0);
	endtask : t_select
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		err_count = 0;
		checked   = 0;
		rst       = 1'b1;
		pod_addr  = ADDR_NONE;
		cos       = 1'b0;
		cmd_idx   = 8'h00;
		cmd_done  = 1'b0;
		tick(12);
		rst = 1'b0;
		tick(2);
		check("txd idle", txd, 1'b1);
		t_nonaddr();
		t_unselected();
		t_select();
		print_verdict();
	end
endmodule : apl_pod_link_tb
